// [verilog/scrm_top.sv]
`timescale 1ns/1ps
`include "scrm_cfg.svh"
// Contract
// - Shift amount is an unsigned count, zero no shift, fifteen at most.
// - Normalise priority-encodes the 16-bit shifter input within the cycle limit.
// - Normalise stores the encoded value in the chosen preset and drives it out.
// - Normalise shifts the input by the encoded amount giving a normalised word.
// - Port-sourced shifts use an internal register that captures the port.
// - Port direction: input for port shifts, output for normalise, else released.
// - Output disable keeps the port an input; sequencer then avoids normalise.
// - Presets load from the encoder by normalise, or from the port by load.
// - Preset loads from the port pass the shifter input unshifted.
// - Two register files, ALU-fed and shifter-fed, each left and right 16-bit.
// - File and selector instructions run the cycle after their capture edge.
// - A file load lands on the edge that ends the execution cycle.
// - Selected file output holds for the whole execution cycle, except under 111, where it follows the file input.
// - Load field: 000/010 left, 001/011 right, 100 both, 101-111 none.
// - Output: right for 000/011/101, left for 001/010/100/110, 111 pass.
// - First operand select: 00 ALU file, 01 A port, 10 B port, 11 shifter file.
// - Second operand: B port or shifter file; shifter input: B port or ALU file.
// - Output port shows ALU file on 0, shifter file on 1.
// - Shifter decodes the sixteen-code instruction into kind and amount source.
// - Logical fill zero, arithmetic fill sign, rotates wrap around.
// - Shift instructions run the cycle after their capture edge.
// - Clear zeroes presets, both register files and the port input registers.
module scrm_top #(
  parameter int W = 16,
  parameter int AW = 4,
  parameter int PAW = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PAW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] shift_instruction,
  input wire logic [2:0] alu_file_instruction,
  input wire logic [2:0] shifter_file_instruction,
  input wire logic a_selector_high_bit,
  input wire logic a_selector_low_bit,
  input wire logic second_operand_select_bit,
  input wire logic shifter_input_select_bit,
  input wire logic output_port_select_bit,
  input wire logic clear_request,
  input wire logic [W-1:0] a_port,
  input wire logic [W-1:0] b_port,
  input wire logic [W-1:0] alu_result,
  input wire logic [AW-1:0] shift_value_port_in,
  output logic [AW-1:0] shift_value_port_out,
  output logic shift_value_port_oe,
  output logic [W-1:0] alu_operand_a,
  output logic [W-1:0] alu_operand_b,
  output logic [W-1:0] output_port
);
  // Encoder finishes in one cycle; the allowed figure is stated in cycles here
  localparam int NormLimitCycles = `SCRM_NORM_LIMIT_NS / `SCRM_CLK_NS;

  logic [3:0] shift_instr_q;
  logic [2:0] afile_instr_q;
  logic [2:0] sfile_instr_q;
  logic [1:0] asel_q;
  logic bsel_q;
  logic ssel_q;
  logic csel_q;
  logic clear_req_q;
  logic [W-1:0] a_port_q;
  logic [W-1:0] b_port_q;
  logic [AW-1:0] port_value_q;
  logic [AW-1:0] shift_preset_a_q;
  logic [AW-1:0] shift_preset_b_q;
  logic [AW-1:0] pe_last_q;
  logic shift_port_output_disable_q;
  logic sw_clear_q;
  logic [W-1:0] operand_a_q;
  logic [W-1:0] operand_b_q;
  logic [W-1:0] output_port_q;
  logic [AW-1:0] sv_out_q;
  logic sv_oe_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  logic clear_now;
  logic [W-1:0] afile_out;
  logic [W-1:0] afile_left;
  logic [W-1:0] afile_right;
  logic [W-1:0] sfile_out;
  logic [W-1:0] sfile_left;
  logic [W-1:0] sfile_right;
  logic [W-1:0] alu_first_operand_selector;
  logic [W-1:0] alu_second_operand_selector;
  logic [W-1:0] shifter_input_selector;
  logic [W-1:0] output_port_selector;
  logic [W-1:0] shift_result;
  logic [AW-1:0] priority_encoder_result;
  logic [AW-1:0] shift_amount;
  scrm_pkg::scrm_kind_type shift_kind;
  scrm_pkg::scrm_src_type shift_src;
  logic apb_access;
  logic apb_fire;

  function automatic logic is_normalise(input logic [3:0] instr);
    is_normalise = (instr == `SCRM_IS_NORM) || (instr == `SCRM_IS_NORM_A) || (instr == `SCRM_IS_NORM_B);
  endfunction : is_normalise

  // Leading-zero count; an all-zero word saturates at the top count
  function automatic logic [AW-1:0] lead_zeros(input logic [W-1:0] data);
    logic [AW-1:0] cnt;
    cnt = AW'(W - 1);
    for (int i = 0; i < W; i++) begin
      if (data[i]) cnt = AW'(W - 1 - i);
    end
    lead_zeros = cnt;
  endfunction : lead_zeros

  function automatic logic reg_mapped(input logic [PAW-1:0] addr);
    reg_mapped = (addr == `SCRM_OFS_CTRL) || (addr == `SCRM_OFS_STATUS) ||
                 (addr == `SCRM_OFS_AFILE) || (addr == `SCRM_OFS_SFILE);
  endfunction : reg_mapped

  assign clear_now = clear_req_q | sw_clear_q;

  // Instruction fields are captured first and executed in the next cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_instr_q <= `SCRM_IS_LSR_PORT;
      afile_instr_q <= `SCRM_RF_HOLD_OUT_RIGHT;
      sfile_instr_q <= `SCRM_RF_HOLD_OUT_RIGHT;
      asel_q <= `SCRM_PICK_ALU_FILE;
      bsel_q <= 1'b0;
      ssel_q <= 1'b0;
      csel_q <= 1'b0;
      clear_req_q <= 1'b0;
    end else begin
      shift_instr_q <= shift_instruction;
      afile_instr_q <= alu_file_instruction;
      sfile_instr_q <= shifter_file_instruction;
      asel_q <= {a_selector_high_bit, a_selector_low_bit};
      bsel_q <= second_operand_select_bit;
      ssel_q <= shifter_input_select_bit;
      csel_q <= output_port_select_bit;
      clear_req_q <= clear_request;
    end
  end

  // Port input registers; zeroed by a clear instead of capturing
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      a_port_q <= '0;
      b_port_q <= '0;
    end else if (clear_now) begin
      a_port_q <= '0;
      b_port_q <= '0;
    end else begin
      a_port_q <= a_port;
      b_port_q <= b_port;
    end
  end

  // While the block drives the port it would only read back its own value
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      port_value_q <= '0;
    end else if (clear_now) begin
      port_value_q <= '0;
    end else if (!sv_oe_q) begin
      port_value_q <= shift_value_port_in;
    end
  end

  scrm_reg_file #(
    .W(W)
  ) u_alu_file (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(clear_now),
    .instr(afile_instr_q),
    .din(alu_result),
    .dout(afile_out),
    .left(afile_left),
    .right(afile_right)
  );

  scrm_reg_file #(
    .W(W)
  ) u_shifter_file (
    .clk_sys(clk_sys),
    .rst(rst),
    .clear(clear_now),
    .instr(sfile_instr_q),
    .din(shift_result),
    .dout(sfile_out),
    .left(sfile_left),
    .right(sfile_right)
  );

  always_comb begin
    case (asel_q)
      `SCRM_PICK_ALU_FILE: alu_first_operand_selector = afile_out;
      `SCRM_PICK_A_PORT: alu_first_operand_selector = a_port_q;
      `SCRM_PICK_B_PORT: alu_first_operand_selector = b_port_q;
      `SCRM_PICK_SHIFTER_FILE: alu_first_operand_selector = sfile_out;
      default: alu_first_operand_selector = afile_out;
    endcase
  end

  assign alu_second_operand_selector = bsel_q ? sfile_out : b_port_q;
  assign shifter_input_selector = ssel_q ? afile_out : b_port_q;
  assign output_port_selector = csel_q ? sfile_out : afile_out;

  assign priority_encoder_result = lead_zeros(shifter_input_selector);

  always_comb begin
    shift_kind = scrm_pkg::kind_pass;
    shift_src = scrm_pkg::src_port;
    case (shift_instr_q)
      `SCRM_IS_LSR_PORT: shift_kind = scrm_pkg::kind_lsr;
      `SCRM_IS_LSL_PORT: shift_kind = scrm_pkg::kind_lsl;
      `SCRM_IS_ROR_PORT: shift_kind = scrm_pkg::kind_ror;
      `SCRM_IS_ROL_PORT: shift_kind = scrm_pkg::kind_rol;
      `SCRM_IS_LSR_A: begin
        shift_kind = scrm_pkg::kind_lsr;
        shift_src = scrm_pkg::src_preset_a;
      end
      `SCRM_IS_LSL_A: begin
        shift_kind = scrm_pkg::kind_lsl;
        shift_src = scrm_pkg::src_preset_a;
      end
      `SCRM_IS_LSR_B: begin
        shift_kind = scrm_pkg::kind_lsr;
        shift_src = scrm_pkg::src_preset_b;
      end
      `SCRM_IS_LSL_B: begin
        shift_kind = scrm_pkg::kind_lsl;
        shift_src = scrm_pkg::src_preset_b;
      end
      `SCRM_IS_LOAD_A,
      `SCRM_IS_LOAD_B: shift_kind = scrm_pkg::kind_pass;
      `SCRM_IS_ASR_PORT: shift_kind = scrm_pkg::kind_asr;
      `SCRM_IS_ASR_A: begin
        shift_kind = scrm_pkg::kind_asr;
        shift_src = scrm_pkg::src_preset_a;
      end
      `SCRM_IS_ASR_B: begin
        shift_kind = scrm_pkg::kind_asr;
        shift_src = scrm_pkg::src_preset_b;
      end
      `SCRM_IS_NORM,
      `SCRM_IS_NORM_A,
      `SCRM_IS_NORM_B: begin
        shift_kind = scrm_pkg::kind_lsl;
        shift_src = scrm_pkg::src_encoder;
      end
      default: shift_kind = scrm_pkg::kind_pass;
    endcase
  end

  always_comb begin
    case (shift_src)
      scrm_pkg::src_port: shift_amount = port_value_q;
      scrm_pkg::src_preset_a: shift_amount = shift_preset_a_q;
      scrm_pkg::src_preset_b: shift_amount = shift_preset_b_q;
      scrm_pkg::src_encoder: shift_amount = priority_encoder_result;
      default: shift_amount = port_value_q;
    endcase
  end

  // Amount is a plain binary place count
  scrm_barrel_shifter #(
    .W(W),
    .AW(AW)
  ) u_shifter (
    .data(shifter_input_selector),
    .amount(shift_amount),
    .kind(shift_kind),
    .result(shift_result)
  );

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_preset_a_q <= '0;
    end else if (clear_now) begin
      shift_preset_a_q <= '0;
    end else if (shift_instr_q == `SCRM_IS_NORM_A) begin
      shift_preset_a_q <= priority_encoder_result;
    end else if (shift_instr_q == `SCRM_IS_LOAD_A) begin
      shift_preset_a_q <= port_value_q;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_preset_b_q <= '0;
    end else if (clear_now) begin
      shift_preset_b_q <= '0;
    end else if (shift_instr_q == `SCRM_IS_NORM_B) begin
      shift_preset_b_q <= priority_encoder_result;
    end else if (shift_instr_q == `SCRM_IS_LOAD_B) begin
      shift_preset_b_q <= port_value_q;
    end
  end

  // Port drive is registered, so value and enable appear one cycle after execution
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sv_out_q <= '0;
      sv_oe_q <= 1'b0;
      pe_last_q <= '0;
    end else begin
      sv_oe_q <= is_normalise(shift_instr_q) && !shift_port_output_disable_q;
      if (is_normalise(shift_instr_q)) begin
        sv_out_q <= priority_encoder_result;
        pe_last_q <= priority_encoder_result;
      end
    end
  end

  // Selected values are sampled over the execution cycle and held the next
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      operand_a_q <= '0;
      operand_b_q <= '0;
      output_port_q <= '0;
    end else begin
      operand_a_q <= alu_first_operand_selector;
      operand_b_q <= alu_second_operand_selector;
      output_port_q <= output_port_selector;
    end
  end

  // One wait state keeps every bus output on a flip-flop
  assign apb_access = psel && penable;
  assign apb_fire = apb_access && pready_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else if (apb_access && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= !reg_mapped(paddr);
      prdata_q <= '0;
      if (!pwrite) begin
        case (paddr)
          `SCRM_OFS_CTRL: prdata_q[`SCRM_CTRL_DIS_BIT] <= shift_port_output_disable_q;
          `SCRM_OFS_STATUS: begin
            prdata_q[`SCRM_ST_PA_LSB +: AW] <= shift_preset_a_q;
            prdata_q[`SCRM_ST_PB_LSB +: AW] <= shift_preset_b_q;
            prdata_q[`SCRM_ST_PE_LSB +: AW] <= pe_last_q;
            prdata_q[`SCRM_ST_OE_BIT] <= sv_oe_q;
          end
          `SCRM_OFS_AFILE: prdata_q <= {afile_right, afile_left};
          `SCRM_OFS_SFILE: prdata_q <= {sfile_right, sfile_left};
          default: prdata_q <= '0;
        endcase
      end
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end
  end

  // Clear bit is a write-one strobe; it reads back as zero
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      shift_port_output_disable_q <= 1'b0;
      sw_clear_q <= 1'b0;
    end else begin
      sw_clear_q <= 1'b0;
      if (apb_fire && pwrite && paddr == `SCRM_OFS_CTRL) begin
        shift_port_output_disable_q <= pwdata[`SCRM_CTRL_DIS_BIT];
        sw_clear_q <= pwdata[`SCRM_CTRL_CLR_BIT];
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign shift_value_port_out = sv_out_q;
  assign shift_value_port_oe = sv_oe_q;
  assign alu_operand_a = operand_a_q;
  assign alu_operand_b = operand_b_q;
  assign output_port = output_port_q;
endmodule : scrm_top

// [common/scrm_cfg.svh]
`ifndef SCRM_CFG_SVH
`define SCRM_CFG_SVH
`define SCRM_OFS_CTRL 8'h00
`define SCRM_OFS_STATUS 8'h04
`define SCRM_OFS_AFILE 8'h08
`define SCRM_OFS_SFILE 8'h0c
`define SCRM_CTRL_DIS_BIT 0
`define SCRM_CTRL_CLR_BIT 1
`define SCRM_ST_PA_LSB 0
`define SCRM_ST_PB_LSB 4
`define SCRM_ST_PE_LSB 8
`define SCRM_ST_OE_BIT 12
`define SCRM_FILE_RIGHT_LSB 16
`define SCRM_IS_LSR_PORT 4'h0
`define SCRM_IS_LSL_PORT 4'h1
`define SCRM_IS_ROR_PORT 4'h2
`define SCRM_IS_ROL_PORT 4'h3
`define SCRM_IS_LSR_A 4'h4
`define SCRM_IS_LSL_A 4'h5
`define SCRM_IS_LSR_B 4'h6
`define SCRM_IS_LSL_B 4'h7
`define SCRM_IS_LOAD_A 4'h8
`define SCRM_IS_LOAD_B 4'h9
`define SCRM_IS_ASR_PORT 4'ha
`define SCRM_IS_ASR_A 4'hb
`define SCRM_IS_ASR_B 4'hc
`define SCRM_IS_NORM 4'hd
`define SCRM_IS_NORM_A 4'he
`define SCRM_IS_NORM_B 4'hf
`define SCRM_RF_LOAD_LEFT_OUT_RIGHT 3'h0
`define SCRM_RF_LOAD_RIGHT_OUT_LEFT 3'h1
`define SCRM_RF_LOAD_LEFT_OUT_LEFT 3'h2
`define SCRM_RF_LOAD_RIGHT_OUT_RIGHT 3'h3
`define SCRM_RF_LOAD_BOTH_OUT_LEFT 3'h4
`define SCRM_RF_HOLD_OUT_RIGHT 3'h5
`define SCRM_RF_HOLD_OUT_LEFT 3'h6
`define SCRM_RF_HOLD_PASS 3'h7
`define SCRM_PICK_ALU_FILE 2'h0
`define SCRM_PICK_A_PORT 2'h1
`define SCRM_PICK_B_PORT 2'h2
`define SCRM_PICK_SHIFTER_FILE 2'h3
`define SCRM_NORM_LIMIT_NS 100
`define SCRM_CLK_NS 40
`endif

// [common/scrm_pkg.sv]
package scrm_pkg;
  typedef enum logic [2:0] {
    kind_pass,
    kind_lsl,
    kind_lsr,
    kind_rol,
    kind_ror,
    kind_asr
  } scrm_kind_type;
  typedef enum logic [1:0] {
    src_port,
    src_preset_a,
    src_preset_b,
    src_encoder
  } scrm_src_type;
endpackage : scrm_pkg

// [verilog/scrm_barrel_shifter.sv]
`timescale 1ns/1ps
module scrm_barrel_shifter #(
  parameter int W = 16,
  parameter int AW = 4
) (
  input wire logic [W-1:0] data,
  input wire logic [AW-1:0] amount,
  input wire scrm_pkg::scrm_kind_type kind,
  output logic [W-1:0] result
);
  logic [2*W-1:0] dbl;
  logic [2*W-1:0] rot;

  always_comb begin
    dbl = {data, data};
    rot = '0;
    result = data;
    case (kind)
      scrm_pkg::kind_lsl: result = data << amount;
      scrm_pkg::kind_lsr: result = data >> amount;
      scrm_pkg::kind_asr: result = W'($signed(data) >>> amount);
      scrm_pkg::kind_rol: begin
        rot = dbl << amount;
        result = rot[2*W-1:W];
      end
      scrm_pkg::kind_ror: begin
        rot = dbl >> amount;
        result = rot[W-1:0];
      end
      default: result = data;
    endcase
  end
endmodule : scrm_barrel_shifter

// [verilog/scrm_reg_file.sv]
`timescale 1ns/1ps
`include "scrm_cfg.svh"
module scrm_reg_file #(
  parameter int W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clear,
  input wire logic [2:0] instr,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout,
  output logic [W-1:0] left,
  output logic [W-1:0] right
);
  logic [W-1:0] left_q;
  logic [W-1:0] right_q;
  logic load_left;
  logic load_right;

  always_comb begin
    load_left = (instr == `SCRM_RF_LOAD_LEFT_OUT_RIGHT) || (instr == `SCRM_RF_LOAD_LEFT_OUT_LEFT) ||
                (instr == `SCRM_RF_LOAD_BOTH_OUT_LEFT);
    load_right = (instr == `SCRM_RF_LOAD_RIGHT_OUT_LEFT) || (instr == `SCRM_RF_LOAD_RIGHT_OUT_RIGHT) ||
                 (instr == `SCRM_RF_LOAD_BOTH_OUT_LEFT);
  end

  // Load lands on the edge that ends the execution cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      left_q <= '0;
      right_q <= '0;
    end else if (clear) begin
      left_q <= '0;
      right_q <= '0;
    end else begin
      if (load_left) left_q <= din;
      if (load_right) right_q <= din;
    end
  end

  always_comb begin
    case (instr)
      `SCRM_RF_LOAD_LEFT_OUT_RIGHT,
      `SCRM_RF_LOAD_RIGHT_OUT_RIGHT,
      `SCRM_RF_HOLD_OUT_RIGHT: dout = right_q;
      `SCRM_RF_HOLD_PASS: dout = din;
      default: dout = left_q;
    endcase
  end

  assign left = left_q;
  assign right = right_q;
endmodule : scrm_reg_file

// [bench/scrm_top_sva.sv]
`timescale 1ns/1ps
module scrm_top_sva #(
  parameter int W = 16,
  parameter int AW = 4,
  parameter int PAW = 8
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PAW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] shift_instruction,
  input wire logic [2:0] alu_file_instruction,
  input wire logic a_selector_high_bit,
  input wire logic a_selector_low_bit,
  input wire logic second_operand_select_bit,
  input wire logic shifter_input_select_bit,
  input wire logic output_port_select_bit,
  input wire logic clear_request,
  input wire logic [W-1:0] a_port,
  input wire logic [W-1:0] b_port,
  input wire logic [W-1:0] alu_result,
  input wire logic [AW-1:0] shift_value_port_out,
  input wire logic shift_value_port_oe,
  input wire logic [W-1:0] alu_operand_a,
  input wire logic [W-1:0] alu_operand_b,
  input wire logic [W-1:0] output_port
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Software clear: a completed write of the clear bit wipes the port registers like the pin does
  logic sw_clr;
  assign sw_clr = psel && penable && pready && pwrite && paddr == '0 && pwdata[1];

  // All-zero input encodes as fifteen, the largest shift
  function automatic logic [3:0] lz(input logic [15:0] v);
    lz = 4'hf;
    for (int i = 0; i < 16; i++) if (v[i]) lz = 4'(15 - i);
  endfunction : lz

  // Selector and port pins reach the outputs two edges later, alu_result one; a clear three edges back wipes the port registers
  a_pass_alu: assert property (($past(alu_file_instruction, 2) == 3'h7
    && !$past(output_port_select_bit, 2)) |-> output_port == $past(alu_result))
    else $error("pass-through result missing");
  a_pick_a_port: assert property ((!$past(a_selector_high_bit, 2) && $past(a_selector_low_bit, 2)
    && !$past(clear_request, 3) && !$past(sw_clr, 3)) |-> alu_operand_a == $past(a_port, 2))
    else $error("operand a not a port");
  a_pick_b_port: assert property (($past(a_selector_high_bit, 2) && !$past(a_selector_low_bit, 2)
    && !$past(clear_request, 3) && !$past(sw_clr, 3)) |-> alu_operand_a == $past(b_port, 2))
    else $error("operand a not b port");
  a_second_b: assert property ((!$past(second_operand_select_bit, 2) && !$past(clear_request, 3)
    && !$past(sw_clr, 3)) |-> alu_operand_b == $past(b_port, 2)) else $error("operand b not b port");
  a_oe_norm: assert property (shift_value_port_oe |-> $past(shift_instruction, 2) >= 4'hd)
    else $error("port driven outside normalise");
  a_oe_release: assert property ($past(shift_instruction, 2) < 4'hd |-> !shift_value_port_oe)
    else $error("port not released");
  a_norm_value: assert property ((shift_value_port_oe && !$past(shifter_input_select_bit, 2)
    && !$past(clear_request, 3) && !$past(sw_clr, 3)) |-> shift_value_port_out == lz($past(b_port, 2)))
    else $error("encoded value wrong on port");
  a_apb_wait: assert property (psel && !penable |=> !pready ##1 pready) else $error("pready timing wrong");
  a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
  a_unmapped_err: assert property (pready |-> pslverr == (paddr > 8'h0c || paddr[1:0] != 2'h0))
    else $error("pslverr wrong");
  a_idle_rdata: assert property (!pready |-> prdata == 32'h0) else $error("prdata not idle zero");
endmodule : scrm_top_sva

// [bench/scrm_seq_model.sv]
`timescale 1ns/1ps
module scrm_seq_model (
  input wire logic [3:0] sv_drive,
  input wire logic [3:0] shift_value_port_out,
  input wire logic shift_value_port_oe,
  output logic [3:0] shift_value_port_in
);
  // Sequencer lets go of the port whenever the device drives it, so no contention
  assign shift_value_port_in = shift_value_port_oe ? shift_value_port_out : sv_drive;
endmodule : scrm_seq_model

// [bench/tb.sv]
`timescale 1ns/1ps
module tb;
  logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e, lft, rgt;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [3:0] shift_instruction = 0, sv_drive = 0, shift_value_port_in, shift_value_port_out;
  logic [2:0] alu_file_instruction = 0, shifter_file_instruction = 0;
  logic a_selector_high_bit = 0, a_selector_low_bit = 0, second_operand_select_bit = 0;
  logic shifter_input_select_bit = 0, output_port_select_bit = 0, clear_request = 0, shift_value_port_oe;
  logic [15:0] a_port = 0, b_port = 0, alu_result = 0, d_a = 0, d_b = 0, d_r = 0;
  logic [15:0] alu_operand_a, alu_operand_b, output_port;
  int bad_count = 0, n_checks = 0, cyc = 0, i, k;

  scrm_top uut (.*);
  scrm_seq_model sq (.*);

  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      wrap_up;
    end
  end

  task wrap_up;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  task chk(input logic [31:0] g, input logic [31:0] w);
    n_checks++;
    if (g !== w) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, w);
    end
  endtask : chk

  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    // Wait states are open-ended; only the cycle ceiling ends a hung transfer
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  task issue(input logic [3:0] sh, input logic [2:0] af, input logic [2:0] sf, input logic [4:0] sel,
             input logic [3:0] v);
    @(posedge clk_sys);
    shift_instruction <= sh;
    alu_file_instruction <= af;
    shifter_file_instruction <= sf;
    {a_selector_high_bit, a_selector_low_bit, second_operand_select_bit, shifter_input_select_bit,
     output_port_select_bit} <= sel;
    sv_drive <= v;
    a_port <= d_a;
    b_port <= d_b;
    alu_result <= d_r;
    @(posedge clk_sys);
    shift_instruction <= 4'h4;
    alu_file_instruction <= 3'h5;
    shifter_file_instruction <= 3'h5;
    @(posedge clk_sys);
    #1;
  endtask : issue

  task clr;
    @(posedge clk_sys);
    clear_request <= 1;
    @(posedge clk_sys);
    clear_request <= 0;
    @(posedge clk_sys);
  endtask : clr

  function automatic logic [15:0] shf(input logic [3:0] c, input logic [15:0] d, input logic [3:0] n);
    logic [31:0] t;
    t = {d, d};
    case (c)
      4'h1, 4'h5, 4'h7: shf = d << n;
      4'h2: shf = 16'(t >> n);
      4'h3: shf = 16'(t >> (5'd16 - n));
      4'ha, 4'hb, 4'hc: shf = 16'($signed(d) >>> n);
      default: shf = d >> n;
    endcase
  endfunction : shf

  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 0;
    apb(8'h04, 0, 0);
    chk(r, 0);
    apb(8'h10, 0, 0);
    chk({31'h0, e}, 1);
    chk(r, 0);
    d_r = 16'h1234;
    d_b = 16'h5a0f;
    for (i = 0; i < 8; i++) begin
      if (i[0]) apb(8'h00, 1, 32'h2);
      else clr;
      issue(4'h8, i[2:0], i[2:0], 5'h00, 4'h5);
      if (i == 7) chk(output_port, 16'h1234);
      lft = (i == 0 || i == 2 || i == 4);
      rgt = (i == 1 || i == 3 || i == 4);
      apb(8'h08, 0, 0);
      chk(r, {rgt ? d_r : 16'h0, lft ? d_r : 16'h0});
      apb(8'h0c, 0, 0);
      chk(r, {rgt ? d_b : 16'h0, lft ? d_b : 16'h0});
    end
    apb(8'h04, 0, 0);
    chk(r & 32'hff, 32'h05);
    d_b = 16'h9a5c;
    issue(4'h8, 3'h5, 3'h5, 5'h00, 4'hf);
    issue(4'h9, 3'h5, 3'h5, 5'h00, 4'h3);
    for (i = 0; i < 13; i++) if (i < 8 || i > 9) begin
      issue(i[3:0], 3'h5, 3'h2, 5'h00, 4'h5);
      chk(shift_value_port_oe, 0);
      apb(8'h0c, 0, 0);
      chk(r[15:0], shf(i[3:0], d_b, (i < 4 || i == 10) ? 4'h5 : (i == 4 || i == 5 || i == 11) ? 4'hf : 4'h3));
    end
    d_b = 16'h0123;
    issue(4'he, 3'h5, 3'h2, 5'h00, 4'h0);
    chk(shift_value_port_oe, 1);
    chk(shift_value_port_out, 4'h7);
    apb(8'h0c, 0, 0);
    chk(r[15:0], 16'h9180);
    issue(4'hf, 3'h5, 3'h5, 5'h00, 4'h0);
    apb(8'h04, 0, 0);
    chk(r & 32'hff, 32'h77);
    apb(8'h00, 1, 32'h1);
    issue(4'hd, 3'h5, 3'h5, 5'h00, 4'h9);
    chk(shift_value_port_oe, 0);
    apb(8'h00, 1, 32'h0);
    clr;
    d_r = 16'h1111;
    d_a = 16'h2222;
    d_b = 16'h3333;
    issue(4'h8, 3'h2, 3'h2, 5'h00, 4'h0);
    d_b = 16'h4444;
    for (k = 0; k < 4; k++) begin
      issue(4'h4, 3'h6, 3'h6, {k[1:0], k[0], 1'b0, k[1]}, 4'h0);
      chk(alu_operand_a, k == 0 ? 16'h1111 : k == 1 ? 16'h2222 : k == 2 ? 16'h4444 : 16'h3333);
      chk(alu_operand_b, k[0] ? 16'h3333 : 16'h4444);
      chk(output_port, k[1] ? 16'h3333 : 16'h1111);
    end
    issue(4'h8, 3'h6, 3'h2, 5'h02, 4'h0);
    apb(8'h0c, 0, 0);
    chk(r[15:0], 16'h1111);
    wrap_up;
  end
endmodule : tb

bind scrm_top scrm_top_sva #(.W(W), .AW(AW), .PAW(PAW)) chk_i (.*);
